// >>> core/wit_pkg.sv
// watch/interval timer: register map, field positions and reset values
// assumes a 34-bit apb byte address (register index times four)
package wit_pkg;

	// ----------------------------------------------------------------
	// register indices; byte address is index times four
	// ----------------------------------------------------------------
	localparam int WIT_ADDR_W = 34;
	localparam logic [31:0] WIT_IDX_WATCH_MODE = 32'hFFFFF680;
	localparam logic [31:0] WIT_IDX_STATUS = 32'hFFFFF681;
	localparam logic [31:0] WIT_IDX_PRESC_MODE = 32'hFFFFF8B0;
	localparam logic [31:0] WIT_IDX_DIV_CMP = 32'hFFFFF8B1;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] WIT_RST_WATCH_MODE = 8'h00;
	localparam logic [7:0] WIT_RST_PRESC_MODE = 8'h00;
	localparam logic [7:0] WIT_RST_DIV_CMP = 8'h00;

	// ----------------------------------------------------------------
	// watch_mode_control fields
	// ----------------------------------------------------------------
	localparam int WIT_WM_RUN = 0;
	localparam int WIT_WM_CNT_RUN = 1;
	localparam int WIT_WM_PER_LO = 2;
	localparam int WIT_WM_PER_HI = 3;
	localparam int WIT_WM_IVAL_LO = 4;
	localparam int WIT_WM_IVAL_HI = 6;
	localparam int WIT_WM_CLK_SEL = 7;

	// ----------------------------------------------------------------
	// prescaler_mode_control fields; other bits read as zero
	// ----------------------------------------------------------------
	localparam int WIT_PM_SRC_LO = 0;
	localparam int WIT_PM_SRC_HI = 1;
	localparam int WIT_PM_CLK_EN = 4;
	localparam logic [7:0] WIT_PM_MASK = 8'h13;

	// ----------------------------------------------------------------
	// counter geometry
	// ----------------------------------------------------------------
	localparam int WIT_PRE_W = 11;
	localparam int WIT_CNT_W = 5;
	localparam logic [11:0] WIT_IVAL_BASE = 12'h010;
	localparam logic [8:0] WIT_SLOW_TAP = 9'h1FF;

endpackage : wit_pkg

// >>> core/wit_sync.sv
// two-flop synchroniser for the subclock pin plus rising-edge pulse
// assumes the pin toggles slower than half the system clock
`timescale 1ns/100ps
module wit_sync (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic pin_in,
	output logic rise_q
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// first flop feeds only the second one
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rise_q <= 1'b0;
		end else begin
			rise_q <= sync_q & ~last_q;
		end
	end
endmodule : wit_sync

// >>> core/wit_count_clock.sv
// main-clock count tick: 2^m source divider then compare divider by 2N
// assumes the settings stay still while enable is high
`timescale 1ns/100ps
module wit_count_clock (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic [1:0] src_sel,
	input wire logic [7:0] compare,
	output logic tick_q
);
	logic [2:0] src_cnt_q;
	logic [8:0] half_cnt_q;
	logic [2:0] src_mask;
	logic src_tick;
	logic [8:0] limit;

	assign src_mask = 3'(({1'b0, 3'h1} << src_sel) - 4'h1);
	assign src_tick = (src_cnt_q & src_mask) == src_mask;
	// zero in the register wraps to 511, i.e. N of 256
	assign limit = 9'({compare, 1'b0} - 9'h001);

	always_ff @(posedge sys_clk) begin
		if (sys_rst || !enable) begin
			src_cnt_q <= 3'h0;
		end else begin
			src_cnt_q <= src_cnt_q + 3'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || !enable) begin
			half_cnt_q <= 9'h000;
		end else if (src_tick) begin
			half_cnt_q <= (half_cnt_q == limit) ? 9'h000 :
				half_cnt_q + 9'h001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= enable & src_tick & (half_cnt_q == limit);
		end
	end
endmodule : wit_count_clock

// >>> core/wit_timer.sv
// watch/interval timer top: apb slave, registers, prescaler, 5-bit counter
// assumes an apb master on sys_clk and a slow subclock on a pin
`timescale 1ns/100ps
module wit_timer (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [wit_pkg::WIT_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sub_clk_pin,
	output logic watch_irq,
	output logic interval_irq
);
	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	logic [7:0] watch_mode_control_q;
	logic [7:0] prescaler_mode_control_q;
	logic [7:0] divider_compare_q;
	logic [31:0] prdata_q;
	logic [31:0] idx;
	logic hit_wm;
	logic hit_st;
	logic hit_pm;
	logic hit_dc;
	logic mapped;
	logic wr_en;
	logic [31:0] rd_mux;
	logic [wit_pkg::WIT_PRE_W-1:0] pre_q;
	logic [wit_pkg::WIT_CNT_W-1:0] cnt_q;

	assign idx = paddr[wit_pkg::WIT_ADDR_W-1:2];
	assign hit_wm = idx == wit_pkg::WIT_IDX_WATCH_MODE;
	assign hit_st = idx == wit_pkg::WIT_IDX_STATUS;
	assign hit_pm = idx == wit_pkg::WIT_IDX_PRESC_MODE;
	assign hit_dc = idx == wit_pkg::WIT_IDX_DIV_CMP;
	assign mapped = hit_wm | hit_st | hit_pm | hit_dc;
	// zero wait states; read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wr_en = psel & penable & pwrite & pstrb[0];
	assign prdata = prdata_q;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_wm) begin
			rd_mux = {24'h000000, watch_mode_control_q};
		end else if (hit_pm) begin
			rd_mux = {24'h000000, prescaler_mode_control_q};
		end else if (hit_dc) begin
			rd_mux = {24'h000000, divider_compare_q};
		end else if (hit_st) begin
			rd_mux = {16'h0000, pre_q, cnt_q};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= rd_mux;
		end
	end

	// whole-byte writes cover the bitwise access too
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			watch_mode_control_q <= wit_pkg::WIT_RST_WATCH_MODE;
		end else if (wr_en && hit_wm) begin
			watch_mode_control_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prescaler_mode_control_q <= wit_pkg::WIT_RST_PRESC_MODE;
		end else if (wr_en && hit_pm) begin
			prescaler_mode_control_q <= pwdata[7:0] & wit_pkg::WIT_PM_MASK;
		end
	end

	// no guard against writes while running; software must not do it
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			divider_compare_q <= wit_pkg::WIT_RST_DIV_CMP;
		end else if (wr_en && hit_dc) begin
			divider_compare_q <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// watch clock selection
	// ----------------------------------------------------------------
	logic clk_en;
	logic brg_tick;
	logic sub_tick;
	logic wtick;
	logic run;
	logic cnt_run;

	assign clk_en = prescaler_mode_control_q[wit_pkg::WIT_PM_CLK_EN];
	assign run = watch_mode_control_q[wit_pkg::WIT_WM_RUN];
	assign cnt_run = watch_mode_control_q[wit_pkg::WIT_WM_CNT_RUN];

	wit_count_clock u_count_clock (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.enable(clk_en),
		.src_sel(prescaler_mode_control_q[wit_pkg::WIT_PM_SRC_HI:
			wit_pkg::WIT_PM_SRC_LO]),
		.compare(divider_compare_q),
		.tick_q(brg_tick)
	);

	// subclock is asynchronous; only its synchronised edge is used
	wit_sync u_sub_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin_in(sub_clk_pin),
		.rise_q(sub_tick)
	);

	assign wtick = watch_mode_control_q[wit_pkg::WIT_WM_CLK_SEL] ?
		(brg_tick & clk_en) : sub_tick;

	// ----------------------------------------------------------------
	// 11-bit prescaler and interval interrupt
	// ----------------------------------------------------------------
	logic [11:0] ival_mask;
	logic ival_hit;
	logic slow_tick;
	logic interval_irq_q;

	assign ival_mask = (wit_pkg::WIT_IVAL_BASE <<
		watch_mode_control_q[wit_pkg::WIT_WM_IVAL_HI:
		wit_pkg::WIT_WM_IVAL_LO]) - 12'h001;
	assign ival_hit = wtick &
		((pre_q & ival_mask[10:0]) == ival_mask[10:0]);
	assign slow_tick = wtick & (pre_q[8:0] == wit_pkg::WIT_SLOW_TAP);

	// runs on bit 0 alone, so clearing bit 1 does not disturb it
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !run) begin
			pre_q <= '0;
		end else if (wtick) begin
			pre_q <= pre_q + 11'h001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			interval_irq_q <= 1'b0;
		end else begin
			interval_irq_q <= run & ival_hit;
		end
	end

	assign interval_irq = interval_irq_q;

	// ----------------------------------------------------------------
	// 5-bit counter and watch interrupt
	// ----------------------------------------------------------------
	logic cnt_src;
	logic cnt_top;
	logic watch_irq_q;

	// codes 1x count the watch clock, 0x count it over 2^9
	assign cnt_src = watch_mode_control_q[wit_pkg::WIT_WM_PER_HI] ?
		wtick : slow_tick;
	assign cnt_top = watch_mode_control_q[wit_pkg::WIT_WM_PER_LO] ?
		(&cnt_q[3:0]) : (&cnt_q);

	// prescaler phase is not reset by bit 1, so the first period may run short
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !run || !cnt_run) begin
			cnt_q <= '0;
		end else if (cnt_src) begin
			cnt_q <= cnt_top ? 5'h00 : cnt_q + 5'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			watch_irq_q <= 1'b0;
		end else begin
			watch_irq_q <= run & cnt_run & cnt_src & cnt_top;
		end
	end

	assign watch_irq = watch_irq_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [12:0] gap_q;
	logic seen_q;
	logic [12:0] gap_exp;

	// shift widened to three bits so m of 3 shifts by four, not zero
	assign gap_exp = ((divider_compare_q == 8'h00) ? 13'h0100 :
		{5'h00, divider_compare_q}) <<
		({1'b0, prescaler_mode_control_q[wit_pkg::WIT_PM_SRC_HI:
		wit_pkg::WIT_PM_SRC_LO]} + 3'h1);

	always_ff @(posedge sys_clk) begin
		if (sys_rst || !clk_en) begin
			gap_q <= 13'h0001;
			seen_q <= 1'b0;
		end else if (brg_tick) begin
			gap_q <= 13'h0001;
			seen_q <= 1'b1;
		end else begin
			gap_q <= gap_q + 13'h0001;
		end
	end

	sequence s_wr_dc;
		wr_en && hit_dc;
	endsequence

	sequence s_stop;
		!run || !cnt_run;
	endsequence

	property p_div_write;
		@(posedge sys_clk) disable iff (sys_rst)
		s_wr_dc |=> divider_compare_q == $past(pwdata[7:0]);
	endproperty
	a_div_write: assert property (p_div_write)
		else $error("divider compare write lost");

	property p_brg_gap;
		@(posedge sys_clk) disable iff (sys_rst)
		(brg_tick && seen_q && $stable(divider_compare_q)) |->
			gap_q == gap_exp;
	endproperty
	a_brg_gap: assert property (p_brg_gap)
		else $error("count clock period wrong");

	property p_wm_write;
		@(posedge sys_clk) disable iff (sys_rst)
		(wr_en && hit_wm) |=> watch_mode_control_q == $past(pwdata[7:0]);
	endproperty
	a_wm_write: assert property (p_wm_write)
		else $error("watch mode write lost");

	property p_cnt_clear;
		@(posedge sys_clk) disable iff (sys_rst)
		s_stop |=> cnt_q == 5'h00;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear)
		else $error("5-bit counter not cleared");

	property p_pre_clear;
		@(posedge sys_clk) disable iff (sys_rst)
		!run |=> pre_q == 11'h000 ##0 !interval_irq;
	endproperty
	a_pre_clear: assert property (p_pre_clear)
		else $error("prescaler not cleared");

	property p_pre_keeps;
		@(posedge sys_clk) disable iff (sys_rst)
		(run && !cnt_run && wtick) |=> pre_q == $past(pre_q) + 11'h001;
	endproperty
	a_pre_keeps: assert property (p_pre_keeps)
		else $error("prescaler disturbed by counter stop");

	property p_no_brg;
		@(posedge sys_clk) disable iff (sys_rst)
		!clk_en |->
			!(watch_mode_control_q[wit_pkg::WIT_WM_CLK_SEL] && wtick)
			##1 !brg_tick;
	endproperty
	a_no_brg: assert property (p_no_brg)
		else $error("count tick without supply enable");

	property p_ival_cause;
		@(posedge sys_clk) disable iff (sys_rst)
		interval_irq |-> $past(run) && $past(wtick) &&
			(($past(pre_q) & $past(ival_mask[10:0])) ==
			$past(ival_mask[10:0]));
	endproperty
	a_ival_cause: assert property (p_ival_cause)
		else $error("interval pulse without interval end");

	property p_watch_cause;
		@(posedge sys_clk) disable iff (sys_rst)
		watch_irq |-> $past(cnt_top) && $past(cnt_src) && cnt_q == 5'h00;
	endproperty
	a_watch_cause: assert property (p_watch_cause)
		else $error("watch pulse without counter wrap");

	property p_one_cycle;
		@(posedge sys_clk) disable iff (sys_rst)
		(watch_irq || interval_irq) |=> !watch_irq && !interval_irq;
	endproperty
	a_one_cycle: assert property (p_one_cycle)
		else $error("interrupt pulse longer than a cycle");

endmodule : wit_timer

// >>> dv/wit_timer_tb.sv
// self-checking bench for the watch/interval timer over apb
// assumes the apb slave answers with pready and a free-running subclock pin
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
	errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
	end end
module wit_timer_tb;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [wit_pkg::WIT_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'h1;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sub_clk_pin = 1'b0;
	logic watch_irq;
	logic interval_irq;
	logic sub_en = 1'b0;
	logic [1:0] sc_cnt = 2'h0;
	int errors = 0;
	int cmp_count = 0;
	int i;

	wit_timer wit_timer_inst (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.sub_clk_pin(sub_clk_pin),
		.watch_irq(watch_irq),
		.interval_irq(interval_irq)
	);

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	// subclock: rising edge every 8 system clocks, free running once on
	always @(posedge sys_clk) begin
		if (sub_en) begin
			sc_cnt <= sc_cnt + 2'h1;
			if (sc_cnt == 2'h3)
				sub_clk_pin <= ~sub_clk_pin;
		end
	end

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	// entered just after a rising edge; one idle edge at the end so the
	// release and the next setup never share a time step
	task automatic apb(input logic [31:0] idx, input bit wr,
		input logic [7:0] wd, output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) begin
			errors++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task automatic wr(input logic [31:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		logic err;
		apb(idx, 1'b1, d, rd, err);
	endtask : wr

	task automatic rd_chk(input logic [31:0] idx, input logic [31:0] exp,
		input logic eerr);
		logic [31:0] rd;
		logic err;
		apb(idx, 1'b0, 8'h00, rd, err);
		`CHK(rd, exp)
		`CHK(err, eerr)
	endtask : rd_chk

	// ----------------------------------------------------------------
	// timer helpers
	// ----------------------------------------------------------------
	// settings only change with both run bits low, divider before supply
	task automatic cfg(input logic [1:0] m, input logic [7:0] n,
		input logic [7:0] wm, input bit sup);
		wr(wit_pkg::WIT_IDX_WATCH_MODE, 8'h00);
		// supply off first, so the divider never changes while it runs
		wr(wit_pkg::WIT_IDX_PRESC_MODE, {6'h00, m});
		wr(wit_pkg::WIT_IDX_DIV_CMP, n);
		wr(wit_pkg::WIT_IDX_PRESC_MODE, {3'h0, sup, 2'h0, m});
		wr(wit_pkg::WIT_IDX_WATCH_MODE, wm);
		wr(wit_pkg::WIT_IDX_WATCH_MODE, wm | 8'h03);
	endtask : cfg

	// spacing between two pulses; the first period is not trusted
	task automatic per(input bit w, input int exp);
		int n;
		n = 0;
		while ((w ? watch_irq : interval_irq) !== 1'b1 && n < 20000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 20000) begin
			errors++;
			stop_test();
		end
		@(posedge sys_clk);
		`CHK(w ? watch_irq : interval_irq, 1'b0)
		n = 1;
		while ((w ? watch_irq : interval_irq) !== 1'b1 && n < 20000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 20000) begin
			errors++;
			stop_test();
		end
		`CHK(n, exp)
	endtask : per

	task automatic quiet(input bit w, input int cyc);
		int c;
		c = 0;
		repeat (cyc) begin
			@(posedge sys_clk);
			if ((w ? watch_irq : interval_irq) !== 1'b0)
				c++;
		end
		`CHK(c, 0)
	endtask : quiet

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd_chk(wit_pkg::WIT_IDX_WATCH_MODE, 32'h00000000, 1'b0);
		rd_chk(wit_pkg::WIT_IDX_DIV_CMP, 32'h00000000, 1'b0);
		rd_chk(wit_pkg::WIT_IDX_PRESC_MODE, 32'h00000000, 1'b0);
		wr(wit_pkg::WIT_IDX_DIV_CMP, 8'hA5);
		rd_chk(wit_pkg::WIT_IDX_DIV_CMP, 32'h000000A5, 1'b0);
		wr(wit_pkg::WIT_IDX_WATCH_MODE, 8'hFC);
		rd_chk(wit_pkg::WIT_IDX_WATCH_MODE, 32'h000000FC, 1'b0);
		rd_chk(32'hFFFFF682, 32'h00000000, 1'b1);
		// fastest derived tick: 2 cycles, interval and watch both 16 ticks
		// odd N with m of zero: the halving procedure stops at once
		cfg(2'h0, 8'h01, 8'h8C, 1'b1);
		per(1'b0, 32);
		per(1'b1, 32);
		// counter run low alone: watch silent, interval undisturbed
		wr(wit_pkg::WIT_IDX_WATCH_MODE, 8'h8D);
		quiet(1'b1, 200);
		per(1'b0, 32);
		wr(wit_pkg::WIT_IDX_WATCH_MODE, 8'h8C);
		quiet(1'b0, 200);
		rd_chk(wit_pkg::WIT_IDX_STATUS, 32'h00000000, 1'b0);
		// every source divider with its own compare and interval code
		for (i = 0; i < 4; i++) begin
			cfg(i[1:0], 8'(i + 1), {1'b1, i[2:0], 4'h8}, 1'b1);
			per(1'b0, (2 << i) * (i + 1) * (16 << i));
			per(1'b1, (2 << i) * (i + 1) * 32);
		end
		// watch code 01: 2^13 ticks through the 2^9 tap
		cfg(2'h0, 8'h01, 8'h84, 1'b1);
		per(1'b1, 2 * 8192);
		cfg(2'h0, 8'h00, 8'h80, 1'b1);
		per(1'b0, 512 * 16);
		cfg(2'h0, 8'h01, 8'h80, 1'b0);
		quiet(1'b0, 400);
		// subclock source: one watch tick per 8 system clocks
		sub_en <= 1'b1;
		cfg(2'h0, 8'h01, 8'h18, 1'b0);
		per(1'b0, 8 * 32);
		per(1'b1, 8 * 32);
		wr(wit_pkg::WIT_IDX_WATCH_MODE, 8'h18);
		stop_test();
	end
endmodule : wit_timer_tb
